//--- hdl/twm_pkg.sv
// Constants, types and register map of the two-wire master transmitter
package twm_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Quarter of one serial bit time
  localparam int unsigned QTR_NS        = 2500;
  localparam int unsigned QTR_CYC       = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  QTR_LAST      = 5'(QTR_CYC - 1);
  localparam logic [4:0]  DIV_ZERO      = 5'h00;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] DATA_OFS  = 8'h08;
  localparam logic [7:0] ROLE_OFS  = 8'h0c;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [1:0] PRESC_RESET = 2'h0;
  localparam logic [7:0] STATUS_MASK = 8'hf8;
  localparam logic [23:0] PAD_ZERO  = 24'h000000;
  localparam logic [31:0] RD_ZERO   = 32'h00000000;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic done;
    logic ack_generate_enable;
    logic start_request;
    logic stop_request;
    logic write_collision_flag;
    logic enable;
    logic reserved;
    logic irq_enable;
  } twm_ctrl_s;

  // ****************************************************************
  // Status codes, prescaler bits masked
  // ****************************************************************
  localparam logic [7:0] SC_START          = 8'h08;
  localparam logic [7:0] SC_RSTART         = 8'h10;
  localparam logic [7:0] ADDRESS_ACKED_CODE = 8'h18;
  localparam logic [7:0] SC_ADDR_NACK      = 8'h20;
  localparam logic [7:0] DATA_ACKED_CODE   = 8'h28;
  localparam logic [7:0] SC_DATA_NACK      = 8'h30;
  localparam logic [7:0] SC_ARB_LOST       = 8'h38;
  localparam logic [7:0] SC_IDLE           = 8'hf8;

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [1:0] PH0       = 2'h0;
  localparam logic [1:0] PH1       = 2'h1;
  localparam logic [1:0] PH2       = 2'h2;
  localparam logic [1:0] PH3       = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT_FREE,
    S_START,
    S_HOLD,
    S_BIT,
    S_RSTART,
    S_STOP
  } twm_state_e;

endpackage

//--- hdl/twm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module twm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // Idle bus level is high, so both stages reset high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      dout   <= '1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

//--- hdl/twm_top.sv
// Two-wire master transmitter with APB register access
//
// Contract
// (R1) Four roles exist; this block runs master transmit
// (R2) Software masks prescaler bits before comparing status
// (R3) Transfer suspended while done flag is set
// (R4) Writing one clears done flag; zero keeps
// (R5) Software keeps enable set in every control write
// (R6) Master role starts with START, then address
// (R7) Start request waits bus free, then START
// (R8) After START, done set with start code
// (R9) Software loads address plus write, clears done
// (R10) After address and ack bit, done set with code
// (R11) Data write with done low discarded, collision set
// (R12) After each data byte and ack, done set
// (R13) Software repeats load and clear until last byte
// (R14) Stop request drives STOP on the bus
// (R15) Start request while holding gives repeated START
// (R16) Write bit low, ack low, eight-bit bytes
// (R17) Codes for address ack, nack, arbitration lost
// (R18) Data byte ack gives 28, nack 30
// (R19) Stop request bit clears after STOP sent
// (R20) Status and data stay stable while done set
`timescale 1ns/1ns
module twm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  twm_pkg::twm_ctrl_s  ctrl_r;
  twm_pkg::twm_ctrl_s  ctrl_nxt;
  twm_pkg::twm_ctrl_s  ctrl_wr;
  twm_pkg::twm_ctrl_s  ctrl_rd;
  twm_pkg::twm_state_e state_r;
  twm_pkg::twm_state_e state_nxt;

  logic [7:0]  data_r;
  logic [7:0]  code_r;
  logic [7:0]  code_nxt;
  logic [1:0]  presc_r;
  logic        role_r;
  logic        role_nxt;
  logic [1:0]  ph_r;
  logic [1:0]  ph_nxt;
  logic [3:0]  bit_r;
  logic [3:0]  bit_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic        addr_next_r;
  logic        addr_next_nxt;
  logic        rep_r;
  logic        rep_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        scl_low_r;
  logic        scl_low_nxt;
  logic        sda_low_r;
  logic        sda_low_nxt;
  logic        done_set;
  logic        stop_clr;
  logic [4:0]  div_r;
  logic        tick_r;
  logic        busy_r;
  logic        scl_q_r;
  logic        sda_q_r;
  logic [31:0] prdata_r;
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  twm_sync #(
    .W (2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({scl_i, sda_i}),
    .dout  (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Open-drain: the pads only ever pull low
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_oe = sda_low_r;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire acc_w    = psel & penable;
  wire setup_w  = psel & ~penable;
  wire wr_acc   = acc_w & pwrite;
  wire sel_ctrl = paddr == twm_pkg::CTRL_OFS;
  wire sel_stat = paddr == twm_pkg::STAT_OFS;
  wire sel_data = paddr == twm_pkg::DATA_OFS;
  wire sel_role = paddr == twm_pkg::ROLE_OFS;
  wire mapped   = sel_ctrl | sel_stat | sel_data | sel_role;
  wire ctrl_we  = wr_acc & sel_ctrl;
  wire stat_we  = wr_acc & sel_stat;
  wire data_we  = wr_acc & sel_data;
  // Data register only accepts writes while the engine is parked
  wire data_ok  = data_we & ctrl_r.done; // R11
  wire data_col = data_we & ~ctrl_r.done; // R11

  // Zero wait states; read data is staged in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc_w & ~mapped;
  assign prdata  = prdata_r;

  assign ctrl_wr = twm_pkg::twm_ctrl_s'(pwdata[7:0]);

  always_comb begin
    ctrl_rd          = ctrl_r;
    ctrl_rd.reserved = 1'b0;
  end

  // Software compares only the masked code; prescaler bits sit below
  wire [7:0] stat_rd = (code_r & twm_pkg::STATUS_MASK) | {6'h00, presc_r}; // R2

  wire [31:0] rd_mux = sel_ctrl ? {twm_pkg::PAD_ZERO, ctrl_rd} :
                       sel_stat ? {twm_pkg::PAD_ZERO, stat_rd} :
                       sel_data ? {twm_pkg::PAD_ZERO, data_r} :
                       sel_role ? {31'h00000000, role_r} :
                       twm_pkg::RD_ZERO;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= twm_pkg::RD_ZERO;
    end else if (setup_w) begin
      prdata_r <= rd_mux;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_we) begin
      ctrl_nxt.ack_generate_enable = ctrl_wr.ack_generate_enable;
      ctrl_nxt.start_request       = ctrl_wr.start_request;
      ctrl_nxt.stop_request        = ctrl_wr.stop_request;
      ctrl_nxt.enable              = ctrl_wr.enable;
      ctrl_nxt.irq_enable          = ctrl_wr.irq_enable;
    end else if (stop_clr) begin
      ctrl_nxt.stop_request = 1'b0; // R19
    end
    // Writing one clears; hardware setting in the same cycle wins
    if (done_set) begin
      ctrl_nxt.done = 1'b1;
    end else if (ctrl_we && ctrl_wr.done) begin
      ctrl_nxt.done = 1'b0; // R4
    end
    if (data_col) begin
      ctrl_nxt.write_collision_flag = 1'b1; // R11
    end else if (data_ok) begin
      ctrl_nxt.write_collision_flag = 1'b0;
    end
    ctrl_nxt.reserved = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= twm_pkg::twm_ctrl_s'(twm_pkg::CTRL_RESET);
      data_r  <= twm_pkg::DATA_RESET;
      presc_r <= twm_pkg::PRESC_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (data_ok) begin
        data_r <= pwdata[7:0]; // R20
      end
      if (stat_we) begin
        presc_r <= pwdata[1:0];
      end
    end
  end

  // ****************************************************************
  // Quarter-bit tick and bus watcher
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= twm_pkg::DIV_ZERO;
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_r == twm_pkg::QTR_LAST;
      div_r  <= (div_r == twm_pkg::QTR_LAST) ? twm_pkg::DIV_ZERO : div_r + 5'h01;
    end
  end

  wire sda_fall = sda_q_r & ~sda_s & scl_s & scl_q_r;
  wire sda_rise = ~sda_q_r & sda_s & scl_s & scl_q_r;

  // Any START on the bus marks it busy until a STOP is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      if (sda_fall) begin
        busy_r <= 1'b1;
      end else if (sda_rise) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  wire run      = ctrl_r.enable;
  wire adv      = tick_r & run;
  wire ack_bit  = bit_r == twm_pkg::BIT_ACK;
  // Released high bit read back low means another master won
  wire arb_lost = ~ack_bit & ~sda_low_r & ~sda_s;

  always_comb begin
    state_nxt     = state_r;
    ph_nxt        = ph_r;
    bit_nxt       = bit_r;
    shift_nxt     = shift_r;
    addr_next_nxt = addr_next_r;
    rep_nxt       = rep_r;
    nack_nxt      = nack_r;
    role_nxt      = role_r;
    code_nxt      = code_r;
    scl_low_nxt   = scl_low_r;
    sda_low_nxt   = sda_low_r;
    done_set      = 1'b0;
    stop_clr      = 1'b0;
    if (!run) begin
      state_nxt   = twm_pkg::S_IDLE;
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
    end else begin
      case (state_r)
        twm_pkg::S_IDLE: begin
          rep_nxt = 1'b0;
          if (ctrl_r.start_request && !ctrl_r.done) begin
            state_nxt = twm_pkg::S_WAIT_FREE; // R7
          end
        end
        twm_pkg::S_WAIT_FREE: begin
          if (adv && !busy_r && scl_s && sda_s) begin
            state_nxt = twm_pkg::S_START; // R7
            ph_nxt    = twm_pkg::PH0;
          end
        end
        twm_pkg::S_START: begin
          if (adv) begin
            ph_nxt = ph_r + 2'h1;
            case (ph_r)
              twm_pkg::PH0: begin
                sda_low_nxt = 1'b1; // R6
              end
              twm_pkg::PH2: begin
                scl_low_nxt   = 1'b1;
                done_set      = 1'b1; // R8
                code_nxt      = rep_r ? twm_pkg::SC_RSTART : twm_pkg::SC_START; // R8
                addr_next_nxt = 1'b1; // R6
                state_nxt     = twm_pkg::S_HOLD;
              end
              default: begin
              end
            endcase
          end
        end
        twm_pkg::S_HOLD: begin
          // SCL stays low until software clears the done flag
          if (!ctrl_r.done) begin // R3
            ph_nxt = twm_pkg::PH0;
            if (ctrl_r.stop_request) begin
              state_nxt = twm_pkg::S_STOP; // R14
            end else if (ctrl_r.start_request) begin
              state_nxt = twm_pkg::S_RSTART; // R15
            end else begin
              state_nxt = twm_pkg::S_BIT;
              bit_nxt   = twm_pkg::BIT_FIRST;
              shift_nxt = data_r;
              if (addr_next_r) begin
                role_nxt = data_r[0]; // R1
              end
            end
          end
        end
        twm_pkg::S_BIT: begin
          if (adv) begin
            case (ph_r)
              twm_pkg::PH0: begin
                // Write bit and data zeros pull SDA low, ones release it; ack slot released
                sda_low_nxt = ack_bit ? 1'b0 : ~shift_r[7]; // R16
                ph_nxt      = twm_pkg::PH1;
              end
              twm_pkg::PH1: begin
                scl_low_nxt = 1'b0;
                ph_nxt      = twm_pkg::PH2;
              end
              twm_pkg::PH2: begin
                // Waiting here honours a slave stretching SCL
                if (scl_s) begin
                  if (arb_lost) begin
                    sda_low_nxt = 1'b0;
                    done_set    = 1'b1;
                    code_nxt    = twm_pkg::SC_ARB_LOST; // R17
                    state_nxt   = twm_pkg::S_IDLE;
                  end else begin
                    nack_nxt = sda_s; // R16
                    ph_nxt   = twm_pkg::PH3;
                  end
                end
              end
              default: begin
                scl_low_nxt = 1'b1;
                ph_nxt      = twm_pkg::PH0;
                if (ack_bit) begin
                  done_set      = 1'b1; // R12
                  addr_next_nxt = 1'b0;
                  state_nxt     = twm_pkg::S_HOLD;
                  if (addr_next_r) begin
                    code_nxt = nack_r ? twm_pkg::SC_ADDR_NACK
                                      : twm_pkg::ADDRESS_ACKED_CODE; // R10
                  end else begin
                    code_nxt = nack_r ? twm_pkg::SC_DATA_NACK
                                      : twm_pkg::DATA_ACKED_CODE; // R18
                  end
                end else begin
                  shift_nxt = {shift_r[6:0], 1'b0};
                  bit_nxt   = bit_r + 4'h1;
                end
              end
            endcase
          end
        end
        twm_pkg::S_RSTART: begin
          if (adv) begin
            case (ph_r)
              twm_pkg::PH0: begin
                sda_low_nxt = 1'b0;
                ph_nxt      = twm_pkg::PH1;
              end
              twm_pkg::PH1: begin
                scl_low_nxt = 1'b0;
                ph_nxt      = twm_pkg::PH2;
              end
              default: begin
                if (scl_s) begin
                  state_nxt = twm_pkg::S_START; // R15
                  rep_nxt   = 1'b1;
                  ph_nxt    = twm_pkg::PH0;
                end
              end
            endcase
          end
        end
        twm_pkg::S_STOP: begin
          if (adv) begin
            case (ph_r)
              twm_pkg::PH0: begin
                sda_low_nxt = 1'b1;
                ph_nxt      = twm_pkg::PH1;
              end
              twm_pkg::PH1: begin
                scl_low_nxt = 1'b0;
                ph_nxt      = twm_pkg::PH2;
              end
              twm_pkg::PH2: begin
                if (scl_s) begin
                  sda_low_nxt = 1'b0; // R14
                  ph_nxt      = twm_pkg::PH3;
                end
              end
              default: begin
                stop_clr  = 1'b1; // R19
                rep_nxt   = 1'b0;
                // Start still requested: STOP then a fresh START
                state_nxt = ctrl_r.start_request ? twm_pkg::S_WAIT_FREE
                                                 : twm_pkg::S_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_nxt = twm_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= twm_pkg::S_IDLE;
      ph_r        <= twm_pkg::PH0;
      bit_r       <= twm_pkg::BIT_FIRST;
      shift_r     <= twm_pkg::DATA_RESET;
      addr_next_r <= 1'b0;
      rep_r       <= 1'b0;
      nack_r      <= 1'b0;
      role_r      <= 1'b0;
      code_r      <= twm_pkg::SC_IDLE;
      scl_low_r   <= 1'b0;
      sda_low_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ph_r        <= ph_nxt;
      bit_r       <= bit_nxt;
      shift_r     <= shift_nxt;
      addr_next_r <= addr_next_nxt;
      rep_r       <= rep_nxt;
      nack_r      <= nack_nxt;
      role_r      <= role_nxt;
      code_r      <= code_nxt; // R20
      scl_low_r   <= scl_low_nxt;
      sda_low_r   <= sda_low_nxt;
    end
  end

endmodule

//--- test/twm_top_assertions.sv
// Concurrent checks on the ports of the two-wire master transmitter
`timescale 1ns/1ns
module twm_top_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  wire acc    = psel && penable;
  wire mapped = paddr inside {twm_pkg::CTRL_OFS, twm_pkg::STAT_OFS,
                              twm_pkg::DATA_OFS, twm_pkg::ROLE_OFS};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Bus conditions
  // ****************************************************************
  sequence start_cond;
    $rose(sda_oe) && !scl_oe && scl_i;
  endsequence
  sequence stop_cond;
    $fell(sda_oe) && !scl_oe && scl_i;
  endsequence

  AST_PREADY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR_BAD: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without slave error");
  AST_SLVERR_OK: assert property (acc && mapped |-> !pslverr)
    else $error("slave error on mapped register");
  AST_RD_UNMAPPED: assert property (acc && !pwrite && !mapped |-> prdata == twm_pkg::RD_ZERO)
    else $error("unmapped read not zero");
  AST_RD_UPPER: assert property (acc && !pwrite |-> prdata[31:8] == twm_pkg::PAD_ZERO)
    else $error("upper read bits not zero");
  AST_STAT_BIT2: assert property (acc && !pwrite && paddr == twm_pkg::STAT_OFS |-> !prdata[2])
    else $error("status bit 2 set");
  AST_LINES_RESET: assert property ($rose(presetn) |-> !scl_oe && !sda_oe)
    else $error("lines pulled right after reset");
  AST_OPEN_DRAIN: assert property (1'b1 |-> !scl_o && !sda_o)
    else $error("line driven high");
  AST_START: assert property (start_cond |-> ##[1:60] scl_oe)
    else $error("clock not pulled low after start");
  AST_STOP: assert property (stop_cond |=> !sda_oe [*8])
    else $error("data pulled again right after stop");
  AST_SCL_HIGH: assert property ($fell(scl_oe) |=> !scl_oe [*8])
    else $error("clock high phase too short");
endmodule

bind twm_top twm_top_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe));

//--- test/twm_slave_model.sv
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/1ns
module twm_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  output logic            sda_oe,
  output logic [7:0]      last_byte,
  output logic            started,
  output logic            stopped
);
  logic [3:0] bit_n;
  logic [7:0] shift;

  initial begin
    sda_oe    = 1'b0;
    last_byte = 8'h00;
    started   = 1'b0;
    stopped   = 1'b0;
    bit_n     = 4'h0;
    shift     = 8'h00;
  end

  // ****************************************************************
  // Start and stop detection
  // ****************************************************************
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      started = 1'b1;
      stopped = 1'b0;
      bit_n   = 4'h0;
      sda_oe  = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1 && started) begin
      stopped = 1'b1;
      started = 1'b0;
    end
  end

  // ****************************************************************
  // Byte receive and acknowledge slot
  // ****************************************************************
  always @(posedge scl) begin
    if (started && bit_n < 4'h8) begin
      shift = {shift[6:0], sda};
    end
    if (started) begin
      bit_n = bit_n + 4'h1;
    end
  end
  // Ack changes only while the clock is low, so it never looks like a stop
  always @(negedge scl) begin
    if (started && bit_n == 4'h8) begin
      last_byte = shift;
      sda_oe    = ~nack;
    end else if (bit_n == 4'h9) begin
      sda_oe = 1'b0;
      bit_n  = 4'h0;
    end
  end
endmodule

//--- test/tb_twm_top.sv
// Self-checking testbench for the two-wire master transmitter
`timescale 1ns/1ns
module tb_twm_top;
  localparam logic [7:0] A_CTRL = twm_pkg::CTRL_OFS;
  localparam logic [7:0] A_STAT = twm_pkg::STAT_OFS;
  localparam logic [7:0] A_DATA = twm_pkg::DATA_OFS;
  logic        pclk         = 1'b0;
  logic        presetn      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h00000000;
  logic        nack         = 1'b0;
  logic        grab         = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe;
  logic        slv_oe, started, stopped;
  logic [7:0]  last_byte;
  // Pull-ups: a line is low only while some party pulls it
  wire         scl_w        = ~scl_oe;
  wire         sda_w        = ~(sda_oe | slv_oe | grab);
  int          n_fail       = 0;
  int          total_checks = 0;

  twm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe));
  twm_slave_model slv_u (.scl(scl_w), .sda(sda_w), .nack(nack), .sda_oe(slv_oe),
    .last_byte(last_byte), .started(started), .stopped(stopped));

  initial begin
    forever #50 pclk = ~pclk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h000000, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h00000000, q);
  endtask
  // Writes control, waits for the done flag, returns the masked status
  task automatic step(input logic [7:0] c, output logic [31:0] sts);
    logic [31:0] q;
    wr(A_CTRL, c);
    q = 32'h00000000;
    for (int i = 0; i < 1000 && q[7] !== 1'b1; i++) rd(A_CTRL, q);
    rd(A_STAT, sts);
    sts = sts & {24'h000000, twm_pkg::STATUS_MASK};
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] q;
    rd(A_CTRL, q);
    chk(q, 32'h00000000);
    rd(A_STAT, q);
    chk(q, 32'h000000f8);
    wr(8'h10, 8'hff);
    rd(8'h10, q);
    chk(q, 32'h00000000);
    rd(A_CTRL, q);
    chk(q, 32'h00000000);
    // Prescaler left set, so later status checks must mask
    wr(A_STAT, 8'h03);
    rd(A_STAT, q);
    chk(q, 32'h000000fb);
  endtask
  task automatic t_start_addr();
    logic [31:0] q;
    step(8'ha4, q);
    chk(q, 32'h08);
    chk({31'h0, started}, 32'h1);
    wr(A_DATA, 8'ha0);
    step(8'h84, q);
    chk(q, 32'h18);
    chk({24'h0, last_byte}, 32'ha0);
  endtask
  task automatic t_hold();
    logic [31:0] q;
    wr(A_CTRL, 8'h04);
    repeat (300) @(posedge pclk);
    chk({31'h0, scl_w}, 32'h0);
    rd(A_CTRL, q);
    chk({31'h0, q[7]}, 32'h1);
    rd(A_STAT, q);
    chk(q, 32'h1b);
  endtask
  task automatic t_data_collide();
    logic [31:0] q;
    wr(A_DATA, 8'h5c);
    wr(A_CTRL, 8'h84);
    wr(A_DATA, 8'hff);
    rd(A_CTRL, q);
    chk({31'h0, q[3]}, 32'h1);
    step(8'h04, q);
    chk(q, 32'h28);
    chk({24'h0, last_byte}, 32'h5c);
    rd(A_DATA, q);
    chk(q, 32'h5c);
  endtask
  task automatic t_nacks();
    logic [31:0] q;
    nack <= 1'b1;
    wr(A_DATA, 8'h3a);
    step(8'h84, q);
    chk(q, 32'h30);
    step(8'ha4, q);
    chk(q, 32'h10);
    chk({31'h0, stopped}, 32'h0);
    // Read bit set in the address, so the role register must show it
    wr(A_DATA, 8'ha1);
    step(8'h84, q);
    chk(q, 32'h20);
    rd(twm_pkg::ROLE_OFS, q);
    chk(q, 32'h1);
    nack <= 1'b0;
  endtask
  task automatic t_stop();
    logic [31:0] q;
    wr(A_CTRL, 8'h94);
    q = 32'h00000010;
    for (int i = 0; i < 1000 && q[4] !== 1'b0; i++) rd(A_CTRL, q);
    chk({31'h0, q[4]}, 32'h0);
    chk({31'h0, stopped}, 32'h1);
  endtask
  // Another party holds data low, so the first one bit loses the bus
  task automatic t_arbitration();
    logic [31:0] q;
    step(8'ha4, q);
    chk(q, 32'h08);
    wr(A_DATA, 8'hff);
    grab <= 1'b1;
    step(8'h84, q);
    chk(q, 32'h38);
    grab <= 1'b0;
  endtask

  // ****************************************************************
  // Verdict and main sequence
  // ****************************************************************
  task automatic results();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start_addr();
    t_hold();
    t_data_collide();
    t_nacks();
    t_stop();
    t_arbitration();
    results();
  end

  // Whole run is near 4600 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    results();
  end
endmodule
